// ==== design/ppsc_pkg.sv ====
// constants, field layouts and carriers of the parallel port status and control registers
package ppsc_pkg;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam int         ADDR_W       = 10;
  localparam logic [7:0] IDX_DATA     = 8'h08; // parallel data port latches
  localparam logic [7:0] IDX_PINS     = 8'h09; // small port pin state
  localparam logic [7:0] IDX_DIR      = 8'h89; // direction and parallel status
  localparam logic [7:0] IDX_ANALOG   = 8'h9F; // analog pin configuration
  localparam logic [7:0] IDX_IRQ_STAT = 8'hC0; // sticky event status
  localparam logic [7:0] IDX_IRQ_MASK = 8'hC1; // event mask

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int IN_FULL_BIT  = 7;
  localparam int OUT_FULL_BIT = 6;
  localparam int OVERFLOW_BIT = 5;
  localparam int PSP_BIT  = 4;
  localparam int MCLR_BIT = 3;
  localparam int DIR_W    = 3;
  localparam int IRQ_DONE_BIT = 0; // transfer complete
  localparam int IRQ_OVF_BIT  = 1; // overflow occurred
  localparam int IRQ_W        = 2;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [7:0]       DIR_RESET    = 8'h0F;
  localparam logic [7:0]       ANALOG_RESET = 8'h00;
  localparam logic [DIR_W-1:0] PINS_RESET   = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_RESET    = 2'h0;
  // delay stages from end of a transfer to its flags, which register one cycle after the last stage (next Q2 then Q4)
  localparam int FLAG_DELAY = 2;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic             input_buffer_full;
    logic             output_buffer_full;
    logic             input_overflow_flag;
    logic             parallel_port_select;
    logic [DIR_W-1:0] pin_direction; // chip select, write, read
  } ppsc_ctl_t;

  typedef struct packed {
    logic chip_select_control_pin_b;
    logic write_control_pin_b;
    logic read_control_pin_b;
  } ppsc_ctlpin_t;

endpackage

// ==== design/ppsc_regs.sv ====
// parallel port status and control register bank with avalon slave
module ppsc_regs
(
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // avalon register bus
  input  wire logic [ppsc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // parallel data pins
  input  wire logic [7:0]                 pdata_in,
  output logic      [7:0]                 pdata_out,
  output logic      [7:0]                 pdata_oe,
  // small port pins
  input  wire ppsc_pkg::ppsc_ctlpin_t     ctl_pin_in,
  input  wire logic                       master_clear_input_pin,
  output logic      [ppsc_pkg::DIR_W-1:0] ctl_pin_out,
  output logic      [ppsc_pkg::DIR_W-1:0] ctl_pin_oe,
  // interrupt
  output logic                            irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [ppsc_pkg::ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction
  function automatic logic [7:0] dir_view(input ppsc_pkg::ppsc_ctl_t c);
    dir_view = {c.input_buffer_full, c.output_buffer_full, c.input_overflow_flag,
                c.parallel_port_select, 1'b1, c.pin_direction};
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic                       wait_reg,  wait_next;
  logic [7:0]                 rdata_reg, rdata_next;
  ppsc_pkg::ppsc_ctl_t        ctl_reg,   ctl_next;
  logic [7:0]                 in_latch_reg,  in_latch_next;
  logic [7:0]                 out_latch_reg, out_latch_next;
  logic [ppsc_pkg::DIR_W-1:0] pins_reg,  pins_next;
  logic [7:0]                 analog_reg, analog_next;
  logic [ppsc_pkg::IRQ_W-1:0] stat_reg,  stat_next;
  logic [ppsc_pkg::IRQ_W-1:0] mask_reg,  mask_next;
  logic                       wr_act_reg, wr_act_next;
  logic                       rd_act_reg, rd_act_next;
  logic [ppsc_pkg::FLAG_DELAY-1:0] wr_dly_reg, wr_dly_next;
  logic [ppsc_pkg::FLAG_DELAY-1:0] rd_dly_reg, rd_dly_next;
  logic [7:0]                 pdata_out_next, pdata_oe_next;
  logic [ppsc_pkg::DIR_W-1:0] pin_oe_next;
  logic                       irq_next;

  logic       wr_now, rd_now, wr_end, rd_end, wr_done, rd_done;
  logic       acc_rd, acc_wr;
  logic [7:0] wbyte;

  // ****************************************************************
  // avalon slave: one wait cycle, read data prepared at the request edge
  // ****************************************************************
  always_comb
  begin
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    if ((avs_read || avs_write) && wait_reg)
    begin
      wait_next  = 1'b0;
      rdata_next = 8'h00; // unmapped reads answer zero
      if (avs_address == byte_addr(ppsc_pkg::IDX_DATA))
        rdata_next = ctl_reg.parallel_port_select ? in_latch_reg : pdata_in;
      else if (avs_address == byte_addr(ppsc_pkg::IDX_PINS))
        rdata_next = {4'h0, master_clear_input_pin, ctl_pin_in};
      else if (avs_address == byte_addr(ppsc_pkg::IDX_DIR))
        rdata_next = dir_view(ctl_reg);
      else if (avs_address == byte_addr(ppsc_pkg::IDX_ANALOG))
        rdata_next = analog_reg;
      else if (avs_address == byte_addr(ppsc_pkg::IDX_IRQ_STAT))
        rdata_next = {6'h00, stat_reg};
      else if (avs_address == byte_addr(ppsc_pkg::IDX_IRQ_MASK))
        rdata_next = {6'h00, mask_reg};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_reg  <= 1'b1;
      rdata_reg <= 8'h00;
    end
    else
    begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = {24'h000000, rdata_reg};

  // accesses complete at the edge where waitrequest is low
  assign acc_rd = avs_read && !wait_reg;
  assign acc_wr = avs_write && !wait_reg && avs_byteenable[0];
  assign wbyte  = avs_writedata[7:0];

  // ****************************************************************
  // external transfer detection, pins are synchronous to sys_clk
  // ****************************************************************
  assign wr_now = ctl_reg.parallel_port_select && !ctl_pin_in.chip_select_control_pin_b
                  && !ctl_pin_in.write_control_pin_b;
  assign rd_now = ctl_reg.parallel_port_select && !ctl_pin_in.chip_select_control_pin_b
                  && !ctl_pin_in.read_control_pin_b;
  assign wr_end  = wr_act_reg && !wr_now; // edge detected end of write, one cycle pulse
  assign rd_end  = rd_act_reg && !rd_now;
  assign wr_done = wr_dly_reg[ppsc_pkg::FLAG_DELAY-1];
  assign rd_done = rd_dly_reg[ppsc_pkg::FLAG_DELAY-1];

  // ****************************************************************
  // flags, latches and pin drive
  // ****************************************************************
  always_comb
  begin
    ctl_next       = ctl_reg;
    in_latch_next  = in_latch_reg;
    out_latch_next = out_latch_reg;
    pins_next      = pins_reg;
    analog_next    = analog_reg;
    stat_next      = stat_reg;
    mask_next      = mask_reg;
    wr_act_next    = wr_now;
    rd_act_next    = rd_now;
    wr_dly_next    = {wr_dly_reg[ppsc_pkg::FLAG_DELAY-2:0], wr_end};
    rd_dly_next    = {rd_dly_reg[ppsc_pkg::FLAG_DELAY-2:0], rd_end};
    // latch follows the pins during the write and freezes at its end
    if (wr_now)
      in_latch_next = pdata_in;

    // software writes; the two full flags are not writable
    if (acc_wr)
    begin
      if (avs_address == byte_addr(ppsc_pkg::IDX_DATA))
        out_latch_next = wbyte;
      else if (avs_address == byte_addr(ppsc_pkg::IDX_PINS))
        pins_next = wbyte[ppsc_pkg::DIR_W-1:0];
      else if (avs_address == byte_addr(ppsc_pkg::IDX_DIR))
      begin
        ctl_next.input_overflow_flag  = wbyte[ppsc_pkg::OVERFLOW_BIT];
        ctl_next.parallel_port_select = wbyte[ppsc_pkg::PSP_BIT];
        ctl_next.pin_direction        = wbyte[ppsc_pkg::DIR_W-1:0];
      end
      else if (avs_address == byte_addr(ppsc_pkg::IDX_ANALOG))
        analog_next = wbyte;
      else if (avs_address == byte_addr(ppsc_pkg::IDX_IRQ_STAT))
        stat_next = stat_reg & ~wbyte[ppsc_pkg::IRQ_W-1:0];
      else if (avs_address == byte_addr(ppsc_pkg::IDX_IRQ_MASK))
        mask_next = wbyte[ppsc_pkg::IRQ_W-1:0];
    end

    // firmware read of the data byte empties the input buffer
    if (acc_rd && avs_address == byte_addr(ppsc_pkg::IDX_DATA))
      ctl_next.input_buffer_full = 1'b0;
    // firmware fill of the output latch, unless a bus read is under way
    if (acc_wr && avs_address == byte_addr(ppsc_pkg::IDX_DATA) && !rd_act_reg)
      ctl_next.output_buffer_full = 1'b1;
    if (rd_act_reg)
      ctl_next.output_buffer_full = 1'b0;

    // completed write: set wins over firmware clears in the same cycle
    if (wr_done && ctl_reg.parallel_port_select)
    begin
      if (ctl_reg.input_buffer_full)
      begin
        ctl_next.input_overflow_flag = 1'b1;
        stat_next[ppsc_pkg::IRQ_OVF_BIT] = 1'b1;
      end
      ctl_next.input_buffer_full = 1'b1;
      stat_next[ppsc_pkg::IRQ_DONE_BIT] = 1'b1;
    end
    if (rd_done && ctl_reg.parallel_port_select)
      stat_next[ppsc_pkg::IRQ_DONE_BIT] = 1'b1;

    // port mode off holds the full flags clear, overflow kept
    if (!ctl_reg.parallel_port_select)
    begin
      ctl_next.input_buffer_full  = 1'b0;
      ctl_next.output_buffer_full = 1'b0;
    end

    // pin drive is registered from the next state, so it changes at the same edge as the state
    pdata_out_next = out_latch_next;
    pdata_oe_next  = rd_now ? 8'hFF : 8'h00;
    pin_oe_next    = ~ctl_next.pin_direction;
    irq_next       = |(stat_next & mask_next);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_reg       <= ppsc_pkg::ppsc_ctl_t'({ppsc_pkg::DIR_RESET[7:4],
                                              ppsc_pkg::DIR_RESET[2:0]});
      in_latch_reg  <= 8'h00;
      out_latch_reg <= 8'h00;
      pins_reg      <= ppsc_pkg::PINS_RESET;
      analog_reg    <= ppsc_pkg::ANALOG_RESET;
      stat_reg      <= ppsc_pkg::IRQ_RESET;
      mask_reg      <= ppsc_pkg::IRQ_RESET;
      wr_act_reg    <= 1'b0;
      rd_act_reg    <= 1'b0;
      wr_dly_reg    <= '0;
      rd_dly_reg    <= '0;
      pdata_out     <= 8'h00;
      pdata_oe      <= 8'h00;
      ctl_pin_out   <= ppsc_pkg::PINS_RESET;
      ctl_pin_oe    <= 3'h0;
      irq           <= 1'b0;
    end
    else
    begin
      ctl_reg       <= ctl_next;
      in_latch_reg  <= in_latch_next;
      out_latch_reg <= out_latch_next;
      pins_reg      <= pins_next;
      analog_reg    <= analog_next;
      stat_reg      <= stat_next;
      mask_reg      <= mask_next;
      wr_act_reg    <= wr_act_next;
      rd_act_reg    <= rd_act_next;
      wr_dly_reg    <= wr_dly_next;
      rd_dly_reg    <= rd_dly_next;
      pdata_out     <= pdata_out_next;
      pdata_oe      <= pdata_oe_next;
      ctl_pin_out   <= pins_next;
      ctl_pin_oe    <= pin_oe_next;
      irq           <= irq_next;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_in_full_after_write;
    (wr_end && ctl_reg.parallel_port_select) ##1 ctl_reg.parallel_port_select [*2]
      |=> ctl_reg.input_buffer_full;
  endproperty
  a_in_full_after_write: assert property (p_in_full_after_write)
    else $error("input full not set three cycles after write end");
  property p_in_full_idle;
    !ctl_reg.input_buffer_full && !wr_done |=> !ctl_reg.input_buffer_full;
  endproperty
  a_in_full_idle: assert property (p_in_full_idle)
    else $error("input full rose without a completed write");
  property p_out_full_fill;
    acc_wr && avs_address == byte_addr(ppsc_pkg::IDX_DATA) && !rd_act_reg
      && ctl_reg.parallel_port_select |=> ctl_reg.output_buffer_full;
  endproperty
  a_out_full_fill: assert property (p_out_full_fill)
    else $error("output full not set after firmware fill");
  property p_out_full_read;
    rd_act_reg |=> !ctl_reg.output_buffer_full;
  endproperty
  a_out_full_read: assert property (p_out_full_read)
    else $error("output full not cleared by bus read");
  property p_overflow_sticky;
    ctl_reg.input_overflow_flag
      && !(acc_wr && avs_address == byte_addr(ppsc_pkg::IDX_DIR))
      |=> ctl_reg.input_overflow_flag;
  endproperty
  a_overflow_sticky: assert property (p_overflow_sticky)
    else $error("overflow flag cleared by hardware");
  property p_overflow_set;
    wr_done && ctl_reg.parallel_port_select && ctl_reg.input_buffer_full
      |=> ctl_reg.input_overflow_flag && stat_reg[ppsc_pkg::IRQ_OVF_BIT];
  endproperty
  a_overflow_set: assert property (p_overflow_set)
    else $error("overflow not flagged on write into full buffer");
  property p_mode_off;
    !ctl_reg.parallel_port_select |=> !ctl_reg.input_buffer_full
      && !ctl_reg.output_buffer_full && pdata_oe == 8'h00;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("full flags or drive active with port mode off");
  property p_dir_drive;
    acc_wr && avs_address == byte_addr(ppsc_pkg::IDX_DIR) |=> ctl_pin_oe == ~$past(wbyte[2:0]);
  endproperty
  a_dir_drive: assert property (p_dir_drive)
    else $error("pin enable does not follow direction bits");
  property p_mclr_one;
    avs_read && !avs_waitrequest && avs_address == byte_addr(ppsc_pkg::IDX_DIR)
      |-> avs_readdata[ppsc_pkg::MCLR_BIT];
  endproperty
  a_mclr_one: assert property (p_mclr_one)
    else $error("master clear direction slot read as zero");
  property p_pins_upper;
    avs_read && !avs_waitrequest && avs_address == byte_addr(ppsc_pkg::IDX_PINS)
      |-> avs_readdata[7:4] == 4'h0;
  endproperty
  a_pins_upper: assert property (p_pins_upper)
    else $error("pin state upper bits not zero");
  property p_in_full_rd_clear;
    acc_rd && avs_address == byte_addr(ppsc_pkg::IDX_DATA) && !wr_done
      |=> !ctl_reg.input_buffer_full;
  endproperty
  a_in_full_rd_clear: assert property (p_in_full_rd_clear)
    else $error("firmware data read did not clear input full");
  property p_ro_flags;
    acc_wr && avs_address == byte_addr(ppsc_pkg::IDX_DIR) && !wr_done && !rd_act_reg
      && ctl_reg.parallel_port_select
      |=> ctl_reg.input_buffer_full == $past(ctl_reg.input_buffer_full)
      && ctl_reg.output_buffer_full == $past(ctl_reg.output_buffer_full);
  endproperty
  a_ro_flags: assert property (p_ro_flags)
    else $error("software write changed a read only full flag");
  property p_mode_select;
    !ctl_reg.parallel_port_select |-> !wr_now && !rd_now;
  endproperty
  a_mode_select: assert property (p_mode_select)
    else $error("transfer detected outside port mode");
endmodule

// ==== test/ppsc_ext_cpu.sv ====
// external byte-wide processor that drives the parallel port control and data pins
module ppsc_ext_cpu
(
  // clock
  input  wire logic                  sys_clk,
  // pins toward the device
  output ppsc_pkg::ppsc_ctlpin_t     ctl_pin_in,
  output logic [7:0]                 pdata_in,
  input  wire logic [7:0]            pdata_out,
  input  wire logic [7:0]            pdata_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // control lines idle high, data lines start with a changing pattern
  initial
  begin
    ctl_pin_in = 3'h7;
    pdata_in   = 8'hA5;
  end

  // one external write of a byte; chip select and write end together
  task automatic ext_write(input logic [7:0] b);
    @(posedge sys_clk);
    ctl_pin_in <= 3'h1;
    pdata_in   <= b;
    repeat (2) @(posedge sys_clk);
    ctl_pin_in <= 3'h7;
    @(posedge sys_clk);
    // released data lines show the inverse so a stale value cannot pass
    pdata_in <= ~b;
  endtask

  // one external read; data and drive enable are taken at the second rising edge,
  // where the enable launched at the first edge has stood a whole cycle
  task automatic ext_read(output logic [7:0] b, output logic [7:0] oe);
    @(posedge sys_clk);
    ctl_pin_in <= 3'h2;
    repeat (2) @(posedge sys_clk);
    b  = pdata_out;
    oe = pdata_oe;
    ctl_pin_in <= 3'h7;
  endtask
endmodule

// ==== test/ppsc_regs_test.sv ====
// self-checking bench of the parallel port status and control registers
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module parallel_port_status_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic                         sys_clk = 1'b0;
  logic                         rst_b   = 1'b0;
  logic [ppsc_pkg::ADDR_W-1:0]  avs_address;
  logic                         avs_read;
  logic                         avs_write;
  logic [31:0]                  avs_writedata;
  logic [3:0]                   avs_byteenable;
  logic [31:0]                  avs_readdata;
  logic                         avs_waitrequest;
  logic [7:0]                   pdata_in;
  logic [7:0]                   pdata_out;
  logic [7:0]                   pdata_oe;
  ppsc_pkg::ppsc_ctlpin_t       ctl_pin_in;
  logic                         master_clear_input_pin;
  logic [ppsc_pkg::DIR_W-1:0]   ctl_pin_out;
  logic [ppsc_pkg::DIR_W-1:0]   ctl_pin_oe;
  logic                         irq;
  int                           err_count   = 0;
  int                           checks_done = 0;
  logic [31:0]                  lfsr_q;

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  ppsc_regs dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pdata_in(pdata_in), .pdata_out(pdata_out),
    .pdata_oe(pdata_oe), .ctl_pin_in(ctl_pin_in),
    .master_clear_input_pin(master_clear_input_pin), .ctl_pin_out(ctl_pin_out),
    .ctl_pin_oe(ctl_pin_oe), .irq(irq));

  ppsc_ext_cpu ext_u (.sys_clk(sys_clk), .ctl_pin_in(ctl_pin_in), .pdata_in(pdata_in),
    .pdata_out(pdata_out), .pdata_oe(pdata_oe));

  // ****************************************************************
  // helpers
  // ****************************************************************
  // random source; a fixed start keeps every run identical
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected direction and status register image
  function automatic logic [7:0] dir_exp(input logic [3:0] flags, input logic [2:0] dir);
    return {flags, 1'b1, dir};
  endfunction

  // one avalon transfer; waitrequest and read data are taken at the rising edge,
  // and only the watchdog ends a wait for an answer that never comes
  task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                          input logic [3:0] be, output logic [7:0] rd);
    @(posedge sys_clk);
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= {24'h000000, wd};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] dmy;
    bus_xfer(1'b1, idx, wd, 4'h1, dmy);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] rd;
    bus_xfer(1'b0, idx, 8'h00, 4'hF, rd);
    `CHK(rd, exp)
  endtask

  // ****************************************************************
  // closing and watchdog
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    test_done();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] got;
    logic [7:0] oe;
    avs_address            = '0;
    avs_read               = 1'b0;
    avs_write              = 1'b0;
    avs_writedata          = 32'h00000000;
    avs_byteenable         = 4'h0;
    master_clear_input_pin = 1'b0;
    lfsr_q                 = 32'h000112F4;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    lfsr_q = lfsr_next(lfsr_next(lfsr_q));
    b1 = lfsr_q[7:0];
    b2 = lfsr_q[15:8] ^ 8'h5A;
    master_clear_input_pin <= lfsr_q[16];
    // reset images and read-only or unimplemented bits
    rd_chk(ppsc_pkg::IDX_DIR, 8'h0F);
    rd_chk(ppsc_pkg::IDX_ANALOG, 8'h00);
    rd_chk(ppsc_pkg::IDX_PINS, {4'h0, lfsr_q[16], 3'h7});
    rd_chk(8'hFF, 8'h00);
    // full flags not writable, master clear slot fixed, direction drives enables
    wr_reg(ppsc_pkg::IDX_DIR, 8'hC2);
    rd_chk(ppsc_pkg::IDX_DIR, 8'h0A);
    `CHK(ctl_pin_oe, 3'h5)
    bus_xfer(1'b1, ppsc_pkg::IDX_DIR, 8'h07, 4'h0, got);
    rd_chk(ppsc_pkg::IDX_DIR, 8'h0A);
    wr_reg(ppsc_pkg::IDX_PINS, b2);
    // the pin latch output is launched at the write edge, look one edge later
    @(posedge sys_clk);
    `CHK(ctl_pin_out, b2[2:0])
    // plain pin mode: external write ignored, overflow kept, data reads live pins
    wr_reg(ppsc_pkg::IDX_DIR, 8'h27);
    ext_u.ext_write(b1);
    repeat (4) @(posedge sys_clk);
    rd_chk(ppsc_pkg::IDX_DIR, dir_exp(4'h2, 3'h7));
    rd_chk(ppsc_pkg::IDX_DATA, ~b1);
    // port mode: received byte sets input full and the done event
    wr_reg(ppsc_pkg::IDX_DIR, 8'h17);
    wr_reg(ppsc_pkg::IDX_IRQ_MASK, 8'h03);
    `CHK(irq, 1'b0)
    ext_u.ext_write(b1);
    repeat (4) @(posedge sys_clk);
    rd_chk(ppsc_pkg::IDX_DIR, dir_exp(4'h9, 3'h7));
    `CHK(irq, 1'b1)
    rd_chk(ppsc_pkg::IDX_IRQ_STAT, 8'h01);
    rd_chk(ppsc_pkg::IDX_DATA, b1);
    rd_chk(ppsc_pkg::IDX_DIR, dir_exp(4'h1, 3'h7));
    // two writes without a read: overflow, newer byte kept, flag stays after read
    ext_u.ext_write(b1);
    ext_u.ext_write(b2);
    repeat (4) @(posedge sys_clk);
    rd_chk(ppsc_pkg::IDX_DIR, dir_exp(4'hB, 3'h7));
    rd_chk(ppsc_pkg::IDX_DATA, b2);
    rd_chk(ppsc_pkg::IDX_DIR, dir_exp(4'h3, 3'h7));
    rd_chk(ppsc_pkg::IDX_IRQ_STAT, 8'h03);
    wr_reg(ppsc_pkg::IDX_DIR, 8'h17);
    rd_chk(ppsc_pkg::IDX_DIR, dir_exp(4'h1, 3'h7));
    wr_reg(ppsc_pkg::IDX_IRQ_STAT, 8'h03);
    rd_chk(ppsc_pkg::IDX_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
    // masked event sets status but not the interrupt line
    wr_reg(ppsc_pkg::IDX_IRQ_MASK, 8'h00);
    ext_u.ext_write(b2);
    repeat (4) @(posedge sys_clk);
    rd_chk(ppsc_pkg::IDX_IRQ_STAT, 8'h01);
    `CHK(irq, 1'b0)
    rd_chk(ppsc_pkg::IDX_DATA, b2);
    wr_reg(ppsc_pkg::IDX_IRQ_STAT, 8'h01);
    // output full set by firmware write, cleared by external read
    wr_reg(ppsc_pkg::IDX_DATA, b1);
    rd_chk(ppsc_pkg::IDX_DIR, dir_exp(4'h5, 3'h7));
    ext_u.ext_read(got, oe);
    `CHK(got, b1)
    `CHK(oe, 8'hFF)
    rd_chk(ppsc_pkg::IDX_DIR, dir_exp(4'h1, 3'h7));
    `CHK(pdata_oe, 8'h00)
    rd_chk(ppsc_pkg::IDX_IRQ_STAT, 8'h01);
    // leaving port mode clears a pending output full
    wr_reg(ppsc_pkg::IDX_DATA, b2);
    wr_reg(ppsc_pkg::IDX_DIR, 8'h07);
    rd_chk(ppsc_pkg::IDX_DIR, 8'h0F);
    test_done();
  end
endmodule
